// ==== core/tweew_slave.sv ====
// Behaviour
// - SDA changes only while SCL low
// - Start is SDA fall, SCL high
// - Stop after read enters standby
// - Ninth clock carries acknowledge, SDA released
// - Acknowledge own slave address after start
// - Acknowledge every byte once write selected
// - Read sends eight bits, samples ack
// - No ack ends read transmission
// - Upper four address bits: type code
// - Next two bits match select pins
// - Next bit is memory address bit 8
// - Last bit: one read, zero write
// - Byte write: word address, then data
// - Stop after write data starts programming
// - Programming ignores the bus entirely
// - Programming self-timed, five milliseconds
// - Page write accepts seven further bytes
// - Write increments three low address bits
// - Counter holds last address plus one
// - Read counter wraps 511 to 0
// - No address ack while programming
`timescale 1ns/1ps
`default_nettype none

module tweew_slave #(
  parameter int unsigned  WRITE_CYCLES = tweew_pkg::WRITE_CYCLES,
  parameter logic [3:0]   TYPE_CODE    = 4'h5  // Arbitrary value
) (
  input  wire logic  clock,
  input  wire logic  nrst,
  input  wire logic  scl_in,
  input  wire logic  sda_in,
  output logic       sda_out,
  output logic       sda_oe,
  input  wire logic  device_select_low_pin,
  input  wire logic  device_select_high_pin,
  output logic       busy,
  output logic       standby
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  tweew_pkg::tweew_state_type                 state_reg;
  logic [3:0]                                 sync_q;
  logic                                       scl_s;
  logic                                       sda_s;
  logic                                       sel_high_s;
  logic                                       sel_low_s;
  logic                                       scl_d_reg;
  logic                                       sda_d_reg;
  logic                                       scl_rise;
  logic                                       scl_fall;
  logic                                       start_det;
  logic                                       stop_det;
  logic [3:0]                                 bit_cnt_reg;
  logic                                       byte_done;
  logic                                       receiving;
  logic [7:0]                                 shift_reg;
  logic [7:0]                                 tx_reg;
  logic                                       rw_reg;
  logic                                       addr8_reg;
  logic [tweew_pkg::ADDR_W-1:0]               addr_cnt_reg;
  logic [tweew_pkg::ADDR_W-tweew_pkg::PAGE_W-1:0] page_hi_reg;
  logic [7:0]                                 page_buf_reg [tweew_pkg::PAGE_BYTES];
  logic [tweew_pkg::PAGE_BYTES-1:0]           page_valid_reg;
  logic                                       data_pending_reg;
  logic                                       busy_reg;
  logic [tweew_pkg::WCNT_W-1:0]               wtimer_reg;
  logic                                       commit;
  logic                                       standby_reg;
  logic                                       sda_oe_reg;
  logic                                       addr_match;
  logic                                       load_now;
  logic [7:0]                                 mem_q;
  logic [7:0]                                 mem_reg [tweew_pkg::MEM_DEPTH];

  localparam logic [tweew_pkg::WCNT_W-1:0] WRITE_LAST =
    tweew_pkg::WCNT_W'(WRITE_CYCLES - 1);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic slave_addr_hit(input logic [7:0] addr_byte,
                                          input logic       sel_high,
                                          input logic       sel_low);
    slave_addr_hit = (addr_byte[tweew_pkg::TYPE_MSB:tweew_pkg::TYPE_LSB] == TYPE_CODE) &&
                     (addr_byte[tweew_pkg::SEL_HIGH_BIT] == sel_high) &&
                     (addr_byte[tweew_pkg::SEL_LOW_BIT] == sel_low);
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  tweew_sync #(
    .WIDTH       (4),
    .RESET_VALUE (4'hF)
  ) u_sync (
    .clock    (clock),
    .nrst     (nrst),
    .async_in ({scl_in, sda_in, device_select_high_pin, device_select_low_pin}),
    .sync_out (sync_q)
  );

  assign scl_s      = sync_q[3];
  assign sda_s      = sync_q[2];
  assign sel_high_s = sync_q[1];
  assign sel_low_s  = sync_q[0];

  // ---------------------------------------------------------------
  // Line event detection
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  // SDA edges with SCL high are framing, never data
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  assign receiving  = (state_reg == tweew_pkg::ST_ADDR) ||
                      (state_reg == tweew_pkg::ST_WORD) ||
                      (state_reg == tweew_pkg::ST_DATA);
  assign byte_done  = scl_fall && (bit_cnt_reg == tweew_pkg::BITS_PER_BYTE);
  assign addr_match = slave_addr_hit(shift_reg, sel_high_s, sel_low_s);
  assign mem_q      = mem_reg[addr_cnt_reg];
  assign load_now   = scl_fall && !busy_reg && !start_det && !stop_det &&
                      (((state_reg == tweew_pkg::ST_ACK_ADDR) && rw_reg) ||
                       (state_reg == tweew_pkg::ST_READ_LOAD));

  // ---------------------------------------------------------------
  // Protocol state machine
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_reg <= tweew_pkg::ST_IDLE;
    end else if (busy_reg) begin
      state_reg <= tweew_pkg::ST_IDLE;
    end else if (start_det) begin
      state_reg <= tweew_pkg::ST_ADDR;
    end else if (stop_det) begin
      state_reg <= tweew_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        tweew_pkg::ST_IDLE, tweew_pkg::ST_WAIT_STOP: begin
          state_reg <= state_reg;
        end
        tweew_pkg::ST_ADDR: begin
          if (byte_done) begin
            state_reg <= addr_match ? tweew_pkg::ST_ACK_ADDR : tweew_pkg::ST_WAIT_STOP;
          end
        end
        tweew_pkg::ST_ACK_ADDR: begin
          if (scl_fall) begin
            state_reg <= rw_reg ? tweew_pkg::ST_READ : tweew_pkg::ST_WORD;
          end
        end
        tweew_pkg::ST_WORD: begin
          if (byte_done) begin
            state_reg <= tweew_pkg::ST_ACK_WORD;
          end
        end
        tweew_pkg::ST_ACK_WORD, tweew_pkg::ST_ACK_DATA: begin
          if (scl_fall) begin
            state_reg <= tweew_pkg::ST_DATA;
          end
        end
        tweew_pkg::ST_DATA: begin
          if (byte_done) begin
            state_reg <= tweew_pkg::ST_ACK_DATA;
          end
        end
        tweew_pkg::ST_READ: begin
          if (byte_done) begin
            state_reg <= tweew_pkg::ST_READ_ACK;
          end
        end
        tweew_pkg::ST_READ_ACK: begin
          if (scl_rise) begin
            state_reg <= sda_s ? tweew_pkg::ST_WAIT_STOP : tweew_pkg::ST_READ_LOAD;
          end
        end
        tweew_pkg::ST_READ_LOAD: begin
          if (scl_fall) begin
            state_reg <= tweew_pkg::ST_READ;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Bit counter and receive shifter
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      bit_cnt_reg <= 4'h0;
    end else if (busy_reg || start_det || stop_det) begin
      bit_cnt_reg <= 4'h0;
    end else if (load_now) begin
      bit_cnt_reg <= 4'h1;
    end else if (receiving || (state_reg == tweew_pkg::ST_READ)) begin
      if (byte_done) begin
        bit_cnt_reg <= 4'h0;
      end else if (receiving && scl_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end else if (!receiving && scl_fall) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end else begin
      bit_cnt_reg <= 4'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      shift_reg <= 8'h00;
    end else if (!busy_reg && receiving && scl_rise) begin
      shift_reg <= {shift_reg[6:0], sda_s};
    end
  end

  // ---------------------------------------------------------------
  // Slave address fields
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rw_reg    <= 1'b0;
      addr8_reg <= 1'b0;
    end else if (!busy_reg && !start_det && !stop_det &&
                 (state_reg == tweew_pkg::ST_ADDR) && byte_done && addr_match) begin
      rw_reg    <= shift_reg[tweew_pkg::RW_BIT];
      addr8_reg <= shift_reg[tweew_pkg::ADDR8_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Address counter and page buffer
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      addr_cnt_reg     <= '0;
      page_hi_reg      <= '0;
      page_valid_reg   <= '0;
      data_pending_reg <= 1'b0;
      for (int i = 0; i < tweew_pkg::PAGE_BYTES; i++) begin
        page_buf_reg[i] <= 8'h00;
      end
    end else if (busy_reg) begin
      data_pending_reg <= 1'b0;
    end else if (start_det) begin
      data_pending_reg <= 1'b0;
    end else if (stop_det) begin
      data_pending_reg <= data_pending_reg;
    end else if (load_now) begin
      addr_cnt_reg <= addr_cnt_reg + 9'h001;
    end else if (byte_done && (state_reg == tweew_pkg::ST_WORD)) begin
      addr_cnt_reg   <= {addr8_reg, shift_reg};
      page_hi_reg    <= {addr8_reg, shift_reg[7:3]};
      page_valid_reg <= '0;
    end else if (byte_done && (state_reg == tweew_pkg::ST_DATA)) begin
      page_buf_reg[addr_cnt_reg[2:0]]   <= shift_reg;
      page_valid_reg[addr_cnt_reg[2:0]] <= 1'b1;
      addr_cnt_reg[2:0]                 <= addr_cnt_reg[2:0] + 3'h1;
      data_pending_reg                  <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Self-timed programming cycle
  // ---------------------------------------------------------------
  assign commit = busy_reg && (wtimer_reg == WRITE_LAST);

  always_ff @(posedge clock) begin
    if (!nrst) begin
      busy_reg   <= 1'b0;
      wtimer_reg <= '0;
    end else if (busy_reg) begin
      if (commit) begin
        busy_reg   <= 1'b0;
        wtimer_reg <= '0;
      end else begin
        wtimer_reg <= wtimer_reg + 1'b1;
      end
    end else if (stop_det && data_pending_reg) begin
      busy_reg   <= 1'b1;
      wtimer_reg <= '0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int i = 0; i < tweew_pkg::MEM_DEPTH; i++) begin
        mem_reg[i] <= tweew_pkg::ERASED_VALUE;
      end
    end else if (commit) begin
      for (int i = 0; i < tweew_pkg::PAGE_BYTES; i++) begin
        if (page_valid_reg[i]) begin
          mem_reg[{page_hi_reg, 3'(i)}] <= page_buf_reg[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Standby tracking
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      standby_reg <= 1'b1;
    end else if (commit) begin
      standby_reg <= 1'b1;
    end else if (busy_reg) begin
      standby_reg <= 1'b0;
    end else if (start_det) begin
      standby_reg <= 1'b0;
    end else if (stop_det) begin
      standby_reg <= ~data_pending_reg;
    end
  end

  // ---------------------------------------------------------------
  // SDA driver and transmit shifter
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sda_oe_reg <= 1'b0;
      tx_reg     <= 8'hFF;
    end else if (busy_reg || start_det || stop_det) begin
      sda_oe_reg <= 1'b0;
    end else if (load_now) begin
      sda_oe_reg <= ~mem_q[7];
      tx_reg     <= {mem_q[6:0], 1'b1};
    end else if (scl_fall) begin
      unique case (state_reg)
        tweew_pkg::ST_ADDR: begin
          if (byte_done) begin
            sda_oe_reg <= addr_match;
          end
        end
        tweew_pkg::ST_WORD, tweew_pkg::ST_DATA: begin
          if (byte_done) begin
            sda_oe_reg <= 1'b1;
          end
        end
        tweew_pkg::ST_READ: begin
          if (byte_done) begin
            sda_oe_reg <= 1'b0;
          end else begin
            sda_oe_reg <= ~tx_reg[7];
            tx_reg     <= {tx_reg[6:0], 1'b1};
          end
        end
        default: begin
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign sda_out = 1'b0;
  assign sda_oe  = sda_oe_reg;
  assign busy    = busy_reg;
  assign standby = standby_reg;

endmodule // tweew_slave

`default_nettype wire

// ==== core/tweew_pkg.sv ====
`default_nettype none

package tweew_pkg;

  // ---------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------
  localparam int unsigned  MEM_DEPTH    = 512;
  localparam int unsigned  ADDR_W       = 9;
  localparam int unsigned  PAGE_BYTES   = 8;
  localparam int unsigned  PAGE_W       = 3;
  localparam logic [7:0]   ERASED_VALUE = 8'hFF;

  // ---------------------------------------------------------------
  // Serial framing
  // ---------------------------------------------------------------
  localparam logic [3:0]   BITS_PER_BYTE = 4'h8;
  localparam int unsigned  TYPE_MSB      = 7;
  localparam int unsigned  TYPE_LSB      = 4;
  localparam int unsigned  SEL_HIGH_BIT  = 3;
  localparam int unsigned  SEL_LOW_BIT   = 2;
  localparam int unsigned  ADDR8_BIT     = 1;
  localparam int unsigned  RW_BIT        = 0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned  CLK_PERIOD_NS = 25;
  localparam int unsigned  WRITE_TIME_MS = 5;
  localparam int unsigned  WRITE_CYCLES  = (WRITE_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned  WCNT_W        = 20;

  // ---------------------------------------------------------------
  // Protocol states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_WORD,
    ST_ACK_WORD,
    ST_DATA,
    ST_ACK_DATA,
    ST_READ,
    ST_READ_ACK,
    ST_READ_LOAD,
    ST_WAIT_STOP
  } tweew_state_type;

endpackage

`default_nettype wire

// ==== core/tweew_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module tweew_sync #(
  parameter int unsigned             WIDTH       = 4,
  parameter logic [WIDTH-1:0]        RESET_VALUE = '1
) (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic [WIDTH-1:0]  async_in,
  output logic      [WIDTH-1:0]  sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // ---------------------------------------------------------------
  // Two-stage synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      meta_reg <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // tweew_sync

`default_nettype wire

// ==== tb/tweew_slave_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module tweew_slave_checker #(
  parameter int unsigned WRITE_CYCLES = 200000
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic device_select_low_pin,
  input wire logic device_select_high_pin,
  input wire logic busy,
  input wire logic standby
);
  // ---------------------------------------------------------------
  // Programming length counter
  // ---------------------------------------------------------------
  logic [31:0] busy_cnt_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  always_ff @(posedge clock) begin
    if (!nrst || !busy) begin
      busy_cnt_reg <= 32'h0;
    end else begin
      busy_cnt_reg <= busy_cnt_reg + 32'h1;
    end
  end

  AST_RESET_QUIET: assert property ($rose(nrst) |-> !sda_oe && !busy && standby)
    else $error("outputs not quiet after reset");
  AST_BUSY_LEN: assert property ($fell(busy) |-> busy_cnt_reg == WRITE_CYCLES)
    else $error("programming length wrong");
  AST_BUSY_DEAF: assert property (busy |-> !sda_oe && !standby)
    else $error("bus answered while programming");
  AST_BUSY_END: assert property ($fell(busy) |-> ##[0:1] standby)
    else $error("no standby after programming");
  AST_SDA_LOW_PHASE: assert property ($changed(sda_oe) |-> !$past(scl_in))
    else $error("data changed while clock high");
  AST_BIT_HOLD: assert property (sda_oe && $rose(scl_in) |-> sda_oe [*3])
    else $error("driven bit not held through high phase");
  AST_START_WAKE: assert property (scl_in && $past(scl_in) && $fell(sda_in) && !busy
    |-> ##[1:6] !standby)
    else $error("start not seen");
  AST_STOP_IDLE: assert property (scl_in && $past(scl_in) && $rose(sda_in) && !busy
    |-> ##[1:6] (standby || busy))
    else $error("stop did not end transfer");

  cover property ($rose(busy));
  cover property ($fell(busy));
  cover property (sda_oe && $rose(scl_in));
endmodule // tweew_slave_checker

bind tweew_slave tweew_slave_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_checker (
  .clock(clock), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .device_select_low_pin(device_select_low_pin),
  .device_select_high_pin(device_select_high_pin), .busy(busy), .standby(standby));

`default_nettype wire

// ==== tb/tweew_master.sv ====
`timescale 1ns/1ps
`default_nettype none

module tweew_master (
  input  wire logic clock,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  // ---------------------------------------------------------------
  // Bus master model, 8 clocks per bit
  // ---------------------------------------------------------------
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  task automatic start();
    sda_pull = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(2);
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask

  task automatic stop();
    sda_pull = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(2);
    sda_pull = 1'b0;
    tick(4);
  endtask

  task automatic bit_io(input logic b, output logic r);
    sda_pull = !b;
    tick(2);
    scl = 1'b1;
    tick(4);
    r = sda;
    scl = 1'b0;
    tick(2);
  endtask

  // Address or data out, read data in, then ninth bit
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(!mack, r);
    ack = !r;
  endtask
endmodule // tweew_master

`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ---------------------------------------------------------------
  // Bench setup
  // ---------------------------------------------------------------
  localparam int unsigned WC   = 300;
  localparam logic [3:0]  TYPE = 4'h6;  // Arbitrary type code
  logic       clock;
  logic       nrst;
  logic       scl;
  logic       sda_pull;
  logic       sel_lo;
  logic       sel_hi;
  logic       sda_oe;
  logic       sda_out;
  logic       busy;
  logic       standby;
  logic       sda;
  logic [7:0] mem [512];
  logic [7:0] q;
  logic [7:0] s;
  logic [8:0] a;
  logic       k;
  int         failures;
  int         samples_checked;
  int         cycles;

  assign sda = !sda_oe && !sda_pull;

  tweew_slave #(.WRITE_CYCLES(WC), .TYPE_CODE(TYPE)) uut (
    .clock(clock), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .device_select_low_pin(sel_lo), .device_select_high_pin(sel_hi),
    .busy(busy), .standby(standby));
  tweew_master m (.clock(clock), .sda(sda), .scl(scl), .sda_pull(sda_pull));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] sla(input logic a8, input logic rw);
    return {TYPE, sel_hi, sel_lo, a8, rw};
  endfunction

  // Word address then n bytes; fin ends with stop and commits to model
  task automatic wr(input logic [8:0] wa, input int n, input logic fin);
    logic [7:0] d;
    logic [8:0] p;
    m.start();
    m.xfer(sla(wa[8], 1'b0), 1'b0, q, k);
    check(k, 1);
    m.xfer(wa[7:0], 1'b0, q, k);
    check(k, 1);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      p = {wa[8:3], wa[2:0] + 3'(i)};
      m.xfer(d, 1'b0, q, k);
      check(k, 1);
      if (fin) mem[p] = d;
    end
    if (fin) m.stop();
  endtask

  // Optional dummy write, then n sequential bytes, last not acknowledged
  task automatic rd(input logic [8:0] ra, input int n, input logic dummy);
    logic [8:0] p;
    p = ra;
    if (dummy) wr(ra, 0, 1'b0);
    m.start();
    m.xfer(sla(1'b0, 1'b1), 1'b0, q, k);
    check(k, 1);
    for (int i = 0; i < n; i++) begin
      m.xfer(8'hFF, i < n - 1, q, k);
      check(q, mem[p]);
      p = p + 9'h1;
    end
    m.stop();
    check(standby, 1);
  endtask

  task automatic poll(input logic exp);
    m.start();
    m.xfer(sla(1'b0, 1'b0), 1'b0, q, k);
    check(k, exp);
    m.stop();
  endtask

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    sel_lo = 1'b0;
    sel_hi = 1'b0;
    foreach (mem[i]) mem[i] = 8'hFF;
    void'($urandom(32'hBAAC7C7E));
    m.tick(8);
    check({sda_out, sda_oe, busy, standby}, 4'h1);
    nrst = 1'b1;
    m.tick(3);
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      {sel_hi, sel_lo} = 2'($urandom);
      s = 8'($urandom) & 8'hFE;
      if (i % 3 == 0) s[7:2] = {TYPE, sel_hi, sel_lo};
      if (i == 1) s[7:2] = {TYPE, !sel_hi, sel_lo};
      if (i == 2) s[7:2] = {TYPE ^ 4'h8, sel_hi, sel_lo};
      m.tick(4);
      m.start();
      m.xfer(s, 1'b0, q, k);
      check(k, s[7:2] == {TYPE, sel_hi, sel_lo});
      m.stop();
    end
    $display("address decode test done");
    for (int j = 0; j < 3; j++) begin
      a = 9'($urandom);
      if (j == 1) a[2:0] = 3'h5;
      wr(a, (j == 0) ? 1 : (j == 1) ? 8 : 1 + $urandom % 8, 1'b1);
      check(busy, 1);
      poll(1'b0);
      repeat (WC) if (busy === 1'b1) m.tick(1);
      check(busy, 0);
      poll(1'b1);
      rd({a[8:3], 3'h0}, 8, 1'b1);
    end
    $display("page write test done");
    rd(9'h1FF, 2, 1'b1);
    rd(9'h001, 1, 1'b0);
    $display("counter wrap test done");
    a = 9'($urandom);
    wr(a, 1, 1'b0);
    rd(a, 1, 1'b1);
    check(busy, 0);
    $display("abandoned write test done");
    tally_and_finish();
  end
endmodule // tb_top

`default_nettype wire
